// ==== rtl/hpsr_top.sv ====
`timescale 1ns/1ns
// Operation
// - Strobe is XNOR of data strobes, OR select
// - Ready low whenever chip select is high
// - Busy shown when selected during unfinished work
// - First data-read half requests DMA, busy until loaded
// - Second data half write/autoinc read sets busy
// - Control and address accesses leave ready alone
// - Select latched at address or transfer strobe fall
// - Read data valid one cycle before ready low
// - During reset ready follows inverted chip select level
// - Reset release answered two cycles later, entry at once
`include "hpsr_regs.svh"
module hpsr_top import hpsr_pkg::*; #(
  parameter int FIFO_DEPTH = `HPSR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Host port pins
  input wire logic port_chip_select_n_in,
  input wire logic data_strobe_one_in,
  input wire logic data_strobe_two_in,
  input wire logic address_strobe_n_in,
  input wire logic [1:0] register_select_in,
  input wire logic read_write_dir_in,
  input wire logic halfword_indicator_in,
  input wire logic [`HPSR_HD_W-1:0] host_data_bus_in,
  output logic [`HPSR_HD_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe_out,
  output logic port_ready_n_out,
  // DMA auxiliary channel reads
  output logic dma_req_out,
  output logic [`HPSR_WORD_W-1:0] dma_addr_out,
  input wire logic dma_ack_in,
  input wire logic [`HPSR_WORD_W-1:0] dma_rdata_in,
  // Write words toward memory
  output logic wr_valid_out,
  output logic [`HPSR_WORD_W-1:0] wr_addr_out,
  output logic [`HPSR_WORD_W-1:0] wr_data_out,
  input wire logic wr_ready_in
);
  localparam int PW = 7 + `HPSR_HD_W;
  localparam int SW = 2 * `HPSR_WORD_W;

  // Pin synchronisers
  logic [PW-1:0] pin_meta, pin_sync;
  logic cs_meta, cs_n_s;
  logic [1:0] rst_pipe;
  logic in_reset;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_meta <= `HPSR_PIN_IDLE;
      pin_sync <= `HPSR_PIN_IDLE;
      rst_pipe <= 2'h0;
    end else begin
      pin_meta <= {data_strobe_one_in, data_strobe_two_in, address_strobe_n_in,
                   register_select_in, read_write_dir_in, halfword_indicator_in,
                   host_data_bus_in};
      pin_sync <= pin_meta;
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  // Chip select keeps running through reset so ready can follow it
  always_ff @(posedge clock_in) begin
    cs_meta <= port_chip_select_n_in;
    cs_n_s <= cs_meta;
  end

  assign in_reset = !rst_pipe[1];

  logic ds1_s, ds2_s, as_n_s;
  hpsr_sel_t sel_now;
  logic [`HPSR_HD_W-1:0] hd_s;
  logic strobe_n;

  assign {ds1_s, ds2_s, as_n_s, sel_now, hd_s} = pin_sync;
  assign strobe_n = ~(ds1_s ^ ds2_s) | cs_n_s;

  // Transfer state
  hpsr_state_t state, next_state;
  hpsr_sel_t sel_q, next_sel_q, cur, next_cur, pick;
  logic sel_held, next_sel_held;
  logic strobe_q, as_q;
  logic [`HPSR_WORD_W-1:0] addr_reg, next_addr, data_reg, next_data;
  logic [`HPSR_HD_W-1:0] ctrl_reg, next_ctrl, next_hd;
  logic next_oe, next_req, next_ready;
  logic strobe_fall, strobe_rise, as_fall, busy;

  hpsr_stream_if #(.WIDTH(SW)) push_if ();
  hpsr_stream_if #(.WIDTH(SW)) pop_if ();

  assign strobe_fall = strobe_q && !strobe_n && !in_reset;
  assign strobe_rise = !strobe_q && strobe_n && !in_reset;
  assign as_fall = as_q && !as_n_s && !in_reset;
  assign pick = sel_held ? sel_q : sel_now;
  assign busy = (state != ST_IDLE);

  always_comb begin
    next_state = state;
    next_sel_q = sel_q;
    next_sel_held = sel_held;
    next_cur = cur;
    next_addr = addr_reg;
    next_data = data_reg;
    next_ctrl = ctrl_reg;
    next_hd = host_data_bus_out;
    next_oe = host_data_bus_oe_out;
    next_req = dma_req_out;
    if (as_fall) begin
      next_sel_q = sel_now;
      next_sel_held = 1'b1;
    end
    if (strobe_fall) begin
      next_cur = pick;
      next_sel_held = 1'b0;
      if (pick.dir == `HPSR_DIR_READ) begin
        next_oe = 1'b1;
        unique case (pick.reg_sel)
          `HPSR_SEL_CTRL: next_hd = ctrl_reg;
          `HPSR_SEL_ADDR: next_hd = hpsr_half(addr_reg, pick.half);
          default: next_hd = hpsr_half(data_reg, pick.half);
        endcase
        if (hpsr_is_data(pick.reg_sel) && pick.half != `HPSR_HW_SECOND &&
            state == ST_IDLE) begin
          next_req = 1'b1;
          next_state = ST_FETCH;
        end
      end
    end
    if (strobe_rise) begin
      next_oe = 1'b0;
      if (cur.dir != `HPSR_DIR_READ) begin
        unique case (cur.reg_sel)
          `HPSR_SEL_CTRL: next_ctrl = hd_s;
          `HPSR_SEL_ADDR: begin
            if (cur.half == `HPSR_HW_SECOND) begin
              next_addr[`HPSR_HD_W-1:0] = hd_s;
            end else begin
              next_addr[`HPSR_WORD_W-1:`HPSR_HD_W] = hd_s;
            end
          end
          default: begin
            if (cur.half == `HPSR_HW_SECOND) begin
              next_data[`HPSR_HD_W-1:0] = hd_s;
            end else begin
              next_data[`HPSR_WORD_W-1:`HPSR_HD_W] = hd_s;
            end
          end
        endcase
      end
      if (hpsr_is_data(cur.reg_sel) && cur.half == `HPSR_HW_SECOND) begin
        if (cur.dir != `HPSR_DIR_READ) begin
          next_state = ST_PUSH;
        end else if (hpsr_is_inc(cur.reg_sel)) begin
          next_addr = addr_reg + `HPSR_ADDR_STEP;
          next_req = 1'b1;
          next_state = ST_FETCH;
        end
      end
    end
    if (state == ST_FETCH && dma_ack_in) begin
      next_req = 1'b0;
      next_data = dma_rdata_in;
      next_state = ST_IDLE;
      if (host_data_bus_oe_out) begin
        next_hd = hpsr_half(dma_rdata_in, cur.half);
      end
    end
    if (state == ST_PUSH && push_if.ready) begin
      next_state = ST_IDLE;
      if (hpsr_is_inc(cur.reg_sel)) begin
        next_addr = addr_reg + `HPSR_ADDR_STEP;
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= ST_IDLE;
      sel_q <= '0;
      sel_held <= 1'b0;
      cur <= '0;
      strobe_q <= 1'b1;
      as_q <= 1'b1;
      addr_reg <= '0;
      data_reg <= '0;
      ctrl_reg <= '0;
      host_data_bus_out <= '0;
      host_data_bus_oe_out <= 1'b0;
      dma_req_out <= 1'b0;
    end else begin
      state <= next_state;
      sel_q <= next_sel_q;
      sel_held <= next_sel_held;
      cur <= next_cur;
      strobe_q <= strobe_n;
      as_q <= as_n_s;
      addr_reg <= next_addr;
      data_reg <= next_data;
      ctrl_reg <= next_ctrl;
      host_data_bus_out <= next_hd;
      host_data_bus_oe_out <= next_oe;
      dma_req_out <= next_req;
    end
  end

  assign dma_addr_out = addr_reg;

  // Ready pin, selected high group or deselected low group in reset
  always_comb begin
    if (in_reset) begin
      next_ready = ~cs_n_s;
    end else if (cs_n_s) begin
      next_ready = 1'b0;
    end else begin
      next_ready = busy;
    end
  end

  always_ff @(posedge clock_in) begin
    port_ready_n_out <= next_ready;
  end

  // Write words queue toward memory
  assign push_if.valid = (state == ST_PUSH);
  assign push_if.data = {addr_reg, data_reg};
  assign pop_if.ready = wr_ready_in;
  assign wr_valid_out = pop_if.valid;
  assign {wr_addr_out, wr_data_out} = pop_if.data;

  hpsr_fifo #(.WIDTH(SW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .fill(push_if.snk),
    .drain(pop_if.src)
  );

  a_ready_deselect: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (!in_reset && cs_n_s) |=> !port_ready_n_out)
    else $error("ready not low while deselected");
  a_busy_on_select: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (!in_reset && $fell(cs_n_s) && busy) |=> port_ready_n_out)
    else $error("ready not busy on select during work");
  a_fetch_request: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (strobe_fall && pick.dir && hpsr_is_data(pick.reg_sel) && !pick.half && !busy)
    |=> dma_req_out && state == ST_FETCH)
    else $error("first data read did not request dma");
  a_fetch_busy: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (!in_reset && state == ST_FETCH && !cs_n_s && $past(state) == ST_FETCH)
    |=> port_ready_n_out)
    else $error("ready low while fetch pending");
  a_second_half: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (strobe_rise && hpsr_is_data(cur.reg_sel) && cur.half &&
     (!cur.dir || hpsr_is_inc(cur.reg_sel))) |=> busy)
    else $error("second half did not set busy");
  a_ctrl_quiet: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    ((strobe_rise || strobe_fall) && !busy && !hpsr_is_data(strobe_fall ? pick.reg_sel :
     cur.reg_sel) && !(state == ST_FETCH)) |=> !busy)
    else $error("control or address access changed ready");
  a_select_latch: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (as_fall && !strobe_fall) |=> sel_held && sel_q == $past(sel_now))
    else $error("select not latched at address strobe");
  a_data_lead: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (state == ST_FETCH && dma_ack_in && host_data_bus_oe_out && !cs_n_s && !strobe_rise)
    |=> host_data_bus_out == hpsr_half($past(dma_rdata_in), cur.half) ##1
    (!port_ready_n_out || cs_n_s))
    else $error("read data not ahead of ready");
  a_reset_follow: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    in_reset |=> port_ready_n_out == !$past(cs_n_s))
    else $error("ready did not follow select in reset");
  a_reset_release: assert property (@(posedge clock_in)
    (!in_reset && $past(in_reset)) |-> $past(arst_n_in, 2))
    else $error("reset released too early");
endmodule

// ==== rtl/hpsr_regs.svh ====
`ifndef HPSR_REGS_SVH
`define HPSR_REGS_SVH

// Register select codes on the host pins
`define HPSR_SEL_CTRL 2'h0
`define HPSR_SEL_DATA_INC 2'h1
`define HPSR_SEL_ADDR 2'h2
`define HPSR_SEL_DATA 2'h3

// Direction and half-word codes
`define HPSR_DIR_READ 1'b1
`define HPSR_HW_SECOND 1'b1

// Widths and reset values
`define HPSR_HD_W 16
`define HPSR_WORD_W 32
`define HPSR_ADDR_STEP 32'h00000004
`define HPSR_PIN_IDLE 23'h700000
`define HPSR_FIFO_DEPTH 8

// Timing
`define HPSR_CLK_PERIOD_NS 40
`define HPSR_RST_RESP_CYC 2

`endif

// ==== rtl/hpsr_pkg.sv ====
package hpsr_pkg;
`include "hpsr_regs.svh"

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_FETCH = 3'h2,
    ST_PUSH = 3'h4
  } hpsr_state_t;

  typedef struct packed {
    logic [1:0] reg_sel;
    logic dir;
    logic half;
  } hpsr_sel_t;

  function automatic logic hpsr_is_data(input logic [1:0] s);
    hpsr_is_data = (s == `HPSR_SEL_DATA) || (s == `HPSR_SEL_DATA_INC);
  endfunction

  function automatic logic hpsr_is_inc(input logic [1:0] s);
    hpsr_is_inc = (s == `HPSR_SEL_DATA_INC);
  endfunction

  function automatic logic [`HPSR_HD_W-1:0] hpsr_half(input logic [`HPSR_WORD_W-1:0] w,
                                                      input logic second);
    hpsr_half = (second == `HPSR_HW_SECOND) ? w[`HPSR_HD_W-1:0] :
                w[`HPSR_WORD_W-1:`HPSR_HD_W];
  endfunction
endpackage

// ==== rtl/hpsr_stream_if.sv ====
`timescale 1ns/1ns
interface hpsr_stream_if #(
  parameter int WIDTH = 64
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/hpsr_fifo.sv ====
`timescale 1ns/1ns
`include "hpsr_regs.svh"
module hpsr_fifo import hpsr_pkg::*; #(
  parameter int WIDTH = 64,
  parameter int DEPTH = `HPSR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // Streams
  hpsr_stream_if.snk fill,
  hpsr_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic do_push, do_pop;

  assign fill.ready = (count != FULL);
  assign drain.valid = (count != '0);
  assign drain.data = mem[rd_ptr];
  assign do_push = fill.valid && fill.ready;
  assign do_pop = drain.valid && drain.ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (do_push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (do_pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (do_push && !do_pop) begin
      next_count = count + 1'b1;
    end else if (do_pop && !do_push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clock_in) begin
    if (do_push) begin
      mem[wr_ptr] <= fill.data;
    end
  end
endmodule

// ==== sim/hpsr_host_model.sv ====
`timescale 1ns/1ns
`include "hpsr_regs.svh"
module hpsr_host_model import hpsr_pkg::*; (
  // Clock
  input wire logic clock_in,
  // Pins toward the port
  output logic cs_n_out,
  output logic [1:0] ds_out,
  output logic as_n_out,
  output hpsr_sel_t sel_out,
  output logic [15:0] wdata_out,
  input wire logic ready_n_in,
  input wire logic [15:0] rdata_in
);
  initial begin
    cs_n_out = 1'b1;
    ds_out = 2'h3;
    as_n_out = 1'b1;
    sel_out = '0;
    wdata_out = 16'h0000;
  end

  task automatic select(input logic v);
    @(negedge clock_in);
    cs_n_out = v;
  endtask

  // One half-word access; the address strobe latches select when used
  task automatic xfer(input hpsr_sel_t s, input logic [15:0] wd, input bit use_as,
                      output logic [15:0] rd, output int busy, output bit late,
                      output logic idle_rdy);
    bit lo;
    int n;
    lo = $urandom_range(1);
    busy = 0;
    n = 0;
    @(negedge clock_in);
    ds_out = {lo, lo};
    cs_n_out = 1'b0;
    sel_out = s;
    wdata_out = (s.dir == `HPSR_DIR_READ) ? ~wd : wd;
    repeat (4) @(negedge clock_in);
    while (ready_n_in !== 1'b0 && n < 4000) begin
      @(negedge clock_in);
      n++;
    end
    if (use_as) begin
      as_n_out = 1'b0;
      repeat (4) @(negedge clock_in);
      sel_out = ~s;
    end
    ds_out[$urandom_range(1)] = ~lo;
    n = 0;
    // Low at least six cycles, then until ready goes low
    while ((ready_n_in !== 1'b0 || n < 6) && n < 4000) begin
      @(negedge clock_in);
      if (ready_n_in !== 1'b0) busy++;
      n++;
      if (n == 2) as_n_out = 1'b1;
    end
    late = (n >= 4000);
    rd = rdata_in;
    ds_out = {lo, lo};
    repeat (4) @(negedge clock_in);
    cs_n_out = 1'b1;
    wdata_out = ~wdata_out;
    repeat (4) @(negedge clock_in);
    idle_rdy = ready_n_in;
  endtask
endmodule

// ==== sim/host_port_strobe_ready_logic_tb_top.sv ====
`timescale 1ns/1ns
`include "hpsr_regs.svh"
module host_port_strobe_ready_logic_tb_top import hpsr_pkg::*;;
  logic clk;
  logic arst_n;
  logic cs_n;
  logic [1:0] ds;
  logic as_n;
  hpsr_sel_t sel;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ready_n;
  logic oe;
  logic dma_req;
  logic dma_ack;
  logic [31:0] dma_addr;
  logic [31:0] dma_rdata;
  logic wr_valid;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_ready;
  logic stall;
  int bad_count;
  int n_compared;
  logic [31:0] exp_addr;
  logic [15:0] exp_ctrl;
  logic [63:0] exp_q[$];

  hpsr_host_model u_host (.clock_in(clk), .cs_n_out(cs_n), .ds_out(ds), .as_n_out(as_n),
    .sel_out(sel), .wdata_out(wdata), .ready_n_in(ready_n), .rdata_in(rdata));

  hpsr_top dut (.clock_in(clk), .arst_n_in(arst_n), .port_chip_select_n_in(cs_n),
    .data_strobe_one_in(ds[0]), .data_strobe_two_in(ds[1]), .address_strobe_n_in(as_n),
    .register_select_in(sel.reg_sel), .read_write_dir_in(sel.dir),
    .halfword_indicator_in(sel.half), .host_data_bus_in(wdata), .host_data_bus_out(rdata),
    .host_data_bus_oe_out(oe), .port_ready_n_out(ready_n), .dma_req_out(dma_req),
    .dma_addr_out(dma_addr), .dma_ack_in(dma_ack), .dma_rdata_in(dma_rdata),
    .wr_valid_out(wr_valid), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
    .wr_ready_in(wr_ready));

  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[15:0] ^ 16'hC3A5, ~a[31:16]};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic acc(input logic [1:0] rs, input logic d, input logic h,
                     input logic [15:0] wd, output logic [15:0] rd, output int busy);
    bit late;
    logic idle_rdy;
    u_host.xfer('{rs, d, h}, wd, $urandom_range(1), rd, busy, late, idle_rdy);
    check(late, 1'b0);
    check(idle_rdy, 1'b0);
    check(oe, 1'b0);
  endtask

  // Whole word as two halves, with expectations
  task automatic word(input logic [1:0] rs, input logic d, input logic [31:0] w);
    logic [15:0] hi;
    logic [15:0] lo;
    int b0;
    int b1;
    acc(rs, d, 1'b0, w[31:16], hi, b0);
    // Expect the word before the second half can push it out
    if (hpsr_is_data(rs) && d != `HPSR_DIR_READ) exp_q.push_back({exp_addr, w});
    acc(rs, d, 1'b1, w[15:0], lo, b1);
    if (!hpsr_is_data(rs)) begin
      check(b0 + b1, 0);
      if (rs == `HPSR_SEL_ADDR && d == `HPSR_DIR_READ) check({hi, lo}, exp_addr);
      if (rs == `HPSR_SEL_ADDR && d != `HPSR_DIR_READ) exp_addr = w;
      if (rs == `HPSR_SEL_CTRL && d == `HPSR_DIR_READ) check({hi, lo}, {2{exp_ctrl}});
      if (rs == `HPSR_SEL_CTRL && d != `HPSR_DIR_READ) exp_ctrl = w[15:0];
    end else if (d == `HPSR_DIR_READ) begin
      check(b0 > 0, 1'b1);
      check({hi, lo}, mem_word(exp_addr));
    end
    if (hpsr_is_inc(rs)) exp_addr = exp_addr + `HPSR_ADDR_STEP;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // DMA auxiliary channel with random latency
  initial begin
    dma_ack = 1'b0;
    dma_rdata = 32'h00000000;
    forever begin
      @(negedge clk);
      dma_ack = 1'b0;
      dma_rdata = ~dma_rdata;
      if (dma_req === 1'b1) begin
        repeat ($urandom_range(8)) @(negedge clk);
        dma_ack = 1'b1;
        dma_rdata = mem_word(dma_addr);
      end
    end
  end

  // Memory side of the write stream
  initial begin
    wr_ready = 1'b0;
    forever begin
      @(negedge clk);
      wr_ready = !stall && $urandom_range(1);
    end
  end

  always @(posedge clk) begin
    if (arst_n && wr_valid === 1'b1 && wr_ready) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0);
      else check({wr_addr, wr_data}, exp_q.pop_front());
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    final_report;
  end

  initial begin
    bad_count = 0;
    n_compared = 0;
    stall = 1'b0;
    exp_addr = 32'h00000000;
    exp_ctrl = 16'h0000;
    arst_n = 1'b0;
    void'($urandom(32'h37FD8C49));
    u_host.select(1'b0);
    repeat (8) @(negedge clk);
    check(ready_n, 1'b1);
    u_host.select(1'b1);
    repeat (6) @(negedge clk);
    check(ready_n, 1'b0);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    $display("test reset done");
    word(`HPSR_SEL_ADDR, 1'b0, 32'h00001000);
    word(`HPSR_SEL_ADDR, 1'b1, 32'h00000000);
    word(`HPSR_SEL_CTRL, 1'b0, 32'h00000055);
    word(`HPSR_SEL_CTRL, 1'b1, 32'h00000000);
    $display("test registers done");
    repeat (30) begin
      if ($urandom_range(5) == 0) word(`HPSR_SEL_ADDR, 1'b0, $urandom & 32'hFFFFFFFC);
      word($urandom_range(1) ? `HPSR_SEL_DATA : `HPSR_SEL_DATA_INC, $urandom_range(1),
           $urandom);
    end
    $display("test random done");
    stall = 1'b1;
    fork
      begin
        repeat (800) @(negedge clk);
        stall = 1'b0;
      end
    join_none
    repeat (12) word(`HPSR_SEL_DATA_INC, 1'b0, $urandom);
    repeat (60) @(negedge clk);
    check(exp_q.size(), 0);
    $display("test fifo stall done");
    final_report;
  end
endmodule
